// >>> hw/pfc_flash_host.sv
`timescale 1ns/10ps
`include "pfc_defs.svh"

// Notes on behaviour
// [RULE_01] Each command write pulses the write strobe low with chip select held low.
// [RULE_02] Device latches the address on the later falling strobe edge.
// [RULE_03] Device latches data on the earlier rising strobe edge.
// [RULE_04] Reads need chip select and output gate both low; host holds both.
// [RULE_05] Device floats its data bus while chip select or output gate is high.
// [RULE_06] Chip select high deselects the device; bus activity is ignored.
// [RULE_07] Host programs single bytes, only into bytes already erased.
// [RULE_08] Program: three guard cycles, then one cycle with target address and data.
// [RULE_09] Programming starts at the fourth rising edge, ends within 20 us.
// [RULE_10] During programming reads return only the two status bits.
// [RULE_11] Commands written during programming are ignored.
// [RULE_12] The array is split into uniform 128-byte erase blocks.
// [RULE_13] Block erase: six cycles, last with block code and block address.
// [RULE_14] Sixth block erase cycle latches address falling, command rising; erase starts.
// [RULE_15] Commands during block erase are ignored.
// [RULE_16] Chip erase: six guarded cycles, last writes 10h at 555h; all ones.
// [RULE_17] Chip erase starts at the sixth rising strobe edge.
// [RULE_18] During chip erase writes are ignored and reads give status only.
// [RULE_19] Bit 7 is inverted-data status, bit 6 alternating status, from start edge.
// [RULE_20] On doubtful status re-read twice; both valid means done, else rejected.
// [RULE_21] Bit 7 reads inverted data while programming, zero while erasing.
// [RULE_22] Bit 6 flips every read while busy and stops once finished.
// [RULE_23] A bad cycle in a guard sequence returns the device to array read.
// [RULE_24] After an operation ends the device reads the array again.
module pfc_flash_host #(
  parameter int AW = 18,
  parameter int ERASE_TO_CYC = `PFC_ERASE_TO_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire pfc_pkg::pfc_op_e cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  // Answer port
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [7:0] rsp_data,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [AW-1:0] flash_addr,
  input wire logic [7:0] flash_dq_i,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe
);
  import pfc_pkg::*;

  localparam logic [7:0] RD_END = 8'(`PFC_ACC_CYC + 4);
  localparam logic [7:0] WP_END = 8'(`PFC_WP_CYC);
  localparam logic [7:0] WR_END = 8'(`PFC_WP_CYC + `PFC_WPH_CYC);

  generate
    if (AW < 12 || AW > 31 || ERASE_TO_CYC < 1) begin : g_bad_param
      $error("pfc_flash_host: AW must be 12..31, ERASE_TO_CYC positive");
    end
  endgenerate

  typedef enum logic [2:0] {
    S_IDLE,
    S_RD,
    S_WR,
    S_POLL,
    S_VER
  } pfc_state_e;

  // Address and data of one write cycle of a guarded sequence
  function automatic logic [AW+7:0] seq_cycle(pfc_op_e op, logic [2:0] idx,
                                              logic [AW-1:0] a, logic [7:0] d);
    logic [AW-1:0] u1;
    logic [AW-1:0] u2;
    logic [AW-1:0] blk;
    u1 = AW'(`PFC_UNLK_A1);
    u2 = AW'(`PFC_UNLK_A2);
    blk = {a[AW-1:`PFC_BLK_BITS], {`PFC_BLK_BITS{1'b0}}};
    unique case (idx)
      3'h0, 3'h3: seq_cycle = (op == PFC_OP_PROG) ? {a, d} : {u1, 8'(`PFC_UNLK_D1)};
      3'h1, 3'h4: seq_cycle = {u2, 8'(`PFC_UNLK_D2)};
      3'h2: seq_cycle = (op == PFC_OP_PROG) ? {u1, 8'(`PFC_CMD_PROG)}
                                            : {u1, 8'(`PFC_CMD_ESETUP)};
      // [RULE_13] [RULE_16] last erase cycle
      default: seq_cycle = (op == PFC_OP_BLK_ERASE) ? {blk, 8'(`PFC_CMD_BLK)}
                          : {AW'(`PFC_CHIP_ADDR), 8'(`PFC_CMD_CHIP)};
    endcase
    if (idx == 3'h0 || idx == 3'h1) begin
      seq_cycle = (idx == 3'h0) ? {u1, 8'(`PFC_UNLK_D1)} : {u2, 8'(`PFC_UNLK_D2)};
    end
  endfunction

  logic [7:0] dq_s;

  pfc_sync #(.W(8)) u_dq_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(flash_dq_i),
    .q(dq_s)
  );

  pfc_state_e state_q, state_d;
  pfc_op_e op_q, op_d;
  logic [AW-1:0] addr_q, addr_d, fa_q, fa_d;
  logic [7:0] data_q, data_d, dqo_q, dqo_d, rd_q, rd_d;
  logic [7:0] cnt_q, cnt_d;
  logic [2:0] idx_q, idx_d;
  logic [1:0] vcnt_q, vcnt_d;
  logic [31:0] tmr_q, tmr_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dqoe_q, dqoe_d;
  logic prev6_q, prev6_d, prev_v_q, prev_v_d;
  logic rsp_v_q, rsp_v_d, rsp_ok_q, rsp_ok_d;
  logic rd_state, rd_done, wr_done, last_cyc;
  logic [7:0] expect_v;
  logic [31:0] limit;

  always_comb begin
    rd_state = (state_q == S_RD) || (state_q == S_POLL) || (state_q == S_VER);
    rd_done = rd_state && (cnt_q == RD_END);
    wr_done = (state_q == S_WR) && (cnt_q == WR_END);
    last_cyc = (op_q == PFC_OP_PROG) ? (idx_q == 3'(`PFC_PROG_LEN - 1))
                                     : (idx_q == 3'(`PFC_ERASE_LEN - 1));
    // Completed program reads true data, completed erase reads all ones
    expect_v = (op_q == PFC_OP_PROG) ? data_q : 8'(`PFC_ERASED);
    limit = (op_q == PFC_OP_PROG) ? 32'(`PFC_PROG_CYC) : 32'(ERASE_TO_CYC);

    state_d = state_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    fa_d = fa_q;
    dqo_d = dqo_q;
    rd_d = rd_q;
    cnt_d = cnt_q + 8'h01;
    idx_d = idx_q;
    vcnt_d = vcnt_q;
    tmr_d = tmr_q;
    prev6_d = prev6_q;
    prev_v_d = prev_v_q;
    rsp_v_d = 1'b0;
    rsp_ok_d = rsp_ok_q;
    ce_n_d = 1'b1;
    oe_n_d = 1'b1;
    we_n_d = 1'b1;
    dqoe_d = 1'b0;

    // [RULE_04] reads with both low
    if (rd_state) begin
      fa_d = addr_q;
      ce_n_d = (cnt_q == 8'h00) || (cnt_q == RD_END);
      oe_n_d = ce_n_d;
    end

    // [RULE_01] strobe with select low
    if (state_q == S_WR) begin
      {fa_d, dqo_d} = seq_cycle(op_q, idx_q, addr_q, data_q);
      dqoe_d = 1'b1;
      ce_n_d = (cnt_q == 8'h00) || (cnt_q > WP_END);
      we_n_d = ce_n_d;
    end

    unique case (state_q)
      S_IDLE: begin
        cnt_d = 8'h00;
        if (cmd_valid) begin
          op_d = cmd_op;
          addr_d = cmd_addr;
          data_d = cmd_data;
          idx_d = 3'h0;
          vcnt_d = 2'h0;
          // [RULE_07] program only checked bytes
          state_d = (cmd_op == PFC_OP_READ || cmd_op == PFC_OP_PROG) ? S_RD : S_WR;
        end
      end
      S_RD: begin
        if (rd_done) begin
          rd_d = dq_s;
          cnt_d = 8'h00;
          if (op_q == PFC_OP_READ) begin
            rsp_v_d = 1'b1;
            rsp_ok_d = 1'b1;
            state_d = S_IDLE;
          end else if (dq_s == 8'(`PFC_ERASED)) begin
            state_d = S_WR;
          end else begin
            rsp_v_d = 1'b1;
            rsp_ok_d = 1'b0;
            state_d = S_IDLE;
          end
        end
      end
      S_WR: begin
        if (wr_done) begin
          cnt_d = 8'h00;
          // [RULE_08] four-cycle program sequence
          if (last_cyc) begin
            state_d = S_POLL;
            tmr_d = 32'h0;
            prev_v_d = 1'b0;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      S_POLL: begin
        tmr_d = tmr_q + 32'h1;
        if (rd_done) begin
          rd_d = dq_s;
          cnt_d = 8'h00;
          prev6_d = dq_s[6];
          prev_v_d = 1'b1;
          // Done once bit 6 stops flipping and bit 7 shows the final value
          if (prev_v_q && dq_s[6] == prev6_q && dq_s[7] == expect_v[7]) begin
            state_d = S_VER;
            vcnt_d = 2'h0;
          end else if (tmr_q >= limit) begin
            rsp_v_d = 1'b1;
            rsp_ok_d = 1'b0;
            state_d = S_IDLE;
          end
        end
      end
      S_VER: begin
        // [RULE_20] two confirming reads
        if (rd_done) begin
          rd_d = dq_s;
          cnt_d = 8'h00;
          vcnt_d = vcnt_q + 2'h1;
          if (dq_s != expect_v) begin
            rsp_v_d = 1'b1;
            rsp_ok_d = 1'b0;
            state_d = S_IDLE;
          end else if (vcnt_q == 2'(`PFC_VERIFY_N - 1)) begin
            rsp_v_d = 1'b1;
            rsp_ok_d = 1'b1;
            state_d = S_IDLE;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= S_IDLE;
      op_q <= PFC_OP_READ;
      addr_q <= '0;
      data_q <= 8'h00;
      fa_q <= '0;
      dqo_q <= 8'h00;
      rd_q <= 8'h00;
      cnt_q <= 8'h00;
      idx_q <= 3'h0;
      vcnt_q <= 2'h0;
      tmr_q <= 32'h0;
      prev6_q <= 1'b0;
      prev_v_q <= 1'b0;
      rsp_v_q <= 1'b0;
      rsp_ok_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dqoe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      fa_q <= fa_d;
      dqo_q <= dqo_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      vcnt_q <= vcnt_d;
      tmr_q <= tmr_d;
      prev6_q <= prev6_d;
      prev_v_q <= prev_v_d;
      rsp_v_q <= rsp_v_d;
      rsp_ok_q <= rsp_ok_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dqoe_q <= dqoe_d;
    end
  end

  assign cmd_ready = (state_q == S_IDLE);
  assign rsp_valid = rsp_v_q;
  assign rsp_ok = rsp_ok_q;
  assign rsp_data = rd_q;
  assign flash_ce_n = ce_n_q;
  assign flash_oe_n = oe_n_q;
  assign flash_we_n = we_n_q;
  assign flash_addr = fa_q;
  assign flash_dq_o = dqo_q;
  assign flash_dq_oe = dqoe_q;

  // Helper counters: write pulses and verify reads per command
  logic [3:0] pulses_q, pulses_d;
  logic [1:0] vreads_q, vreads_d;

  always_comb begin
    pulses_d = pulses_q;
    vreads_d = vreads_q;
    if (cmd_valid && cmd_ready) begin
      pulses_d = 4'h0;
      vreads_d = 2'h0;
    end else begin
      if (we_n_q && !we_n_d) begin
        pulses_d = pulses_q + 4'h1;
      end
      if (state_q == S_VER && rd_done) begin
        vreads_d = vreads_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pulses_q <= 4'h0;
      vreads_q <= 2'h0;
    end else begin
      pulses_q <= pulses_d;
      vreads_q <= vreads_d;
    end
  end

  chk_we_with_ce: assert property ( // [RULE_01]
    @(posedge clk_sys) disable iff (srst) !flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe low without chip select");

  chk_read_gates: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (srst)
    rd_done |-> !flash_ce_n && !flash_oe_n && !flash_dq_oe && $past(!flash_oe_n, 2))
    else $error("read sampled without both gates low");

  chk_prog_erased: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (srst)
    (state_q == S_RD && rd_done && op_q == PFC_OP_PROG && dq_s != 8'hff) |=> state_q == S_IDLE
    ##0 rsp_valid && !rsp_ok && pulses_q == 4'h0)
    else $error("program attempted on unerased byte");

  chk_prog_len: assert property ( // [RULE_08]
    @(posedge clk_sys) disable iff (srst)
    (wr_done && last_cyc && op_q == PFC_OP_PROG) |-> pulses_q == 4'h4
    ##1 (state_q == S_POLL && flash_addr == addr_q))
    else $error("program sequence not four cycles");

  chk_blk_last: assert property ( // [RULE_13]
    @(posedge clk_sys) disable iff (srst)
    ($fell(flash_we_n) && op_q == PFC_OP_BLK_ERASE && pulses_q == 4'h6)
    |-> flash_dq_o == 8'h20 && flash_addr[6:0] == 7'h00
    && flash_addr[AW-1:7] == addr_q[AW-1:7])
    else $error("block erase last cycle wrong");

  chk_chip_last: assert property ( // [RULE_16]
    @(posedge clk_sys) disable iff (srst)
    ($fell(flash_we_n) && op_q == PFC_OP_CHIP_ERASE && pulses_q == 4'h6)
    |-> flash_dq_o == 8'h10 && flash_addr == AW'(12'h555))
    else $error("chip erase last cycle wrong");

  chk_verify_two: assert property ( // [RULE_20]
    @(posedge clk_sys) disable iff (srst)
    (rsp_valid && rsp_ok && op_q != PFC_OP_READ) |-> vreads_q == 2'h2
    && rsp_data == ((op_q == PFC_OP_PROG) ? data_q : 8'hff))
    else $error("write reported done without two good reads");

endmodule // pfc_flash_host

// >>> inc/pfc_defs.svh
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

// System clock period
`define PFC_CLK_NS 20

// Bus timing in ns
`define PFC_T_ACC_NS 70
`define PFC_T_WP_NS 70
`define PFC_T_WPH_NS 40
`define PFC_T_PROG_NS 20000

// Bus timing in clock cycles; least times round up, longest round down
`define PFC_ACC_CYC ((`PFC_T_ACC_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_WP_CYC ((`PFC_T_WP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_WPH_CYC ((`PFC_T_WPH_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_PROG_CYC (`PFC_T_PROG_NS / `PFC_CLK_NS)

// Default erase timeout in cycles (100 ms)
`define PFC_ERASE_TO_CYC 5000000

// Erase block layout: 128-byte blocks
`define PFC_BLK_BITS 7

// Guard sequence addresses and codes
`define PFC_UNLK_A1 12'h555
`define PFC_UNLK_A2 12'h2aa
`define PFC_UNLK_D1 8'haa
`define PFC_UNLK_D2 8'h55
`define PFC_CMD_PROG 8'ha0
`define PFC_CMD_ESETUP 8'h80
`define PFC_CMD_BLK 8'h20
`define PFC_CMD_CHIP 8'h10
`define PFC_CHIP_ADDR 12'h555

// Erased byte value and verify read count
`define PFC_ERASED 8'hff
`define PFC_VERIFY_N 2

// Write cycle counts per sequence
`define PFC_PROG_LEN 4
`define PFC_ERASE_LEN 6

`endif

// >>> inc/pfc_pkg.sv
package pfc_pkg;

  // Operations offered on the command port
  typedef enum logic [1:0] {
    PFC_OP_READ,
    PFC_OP_PROG,
    PFC_OP_BLK_ERASE,
    PFC_OP_CHIP_ERASE
  } pfc_op_e;

endpackage

// >>> hw/pfc_sync.sv
`timescale 1ns/10ps

module pfc_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Asynchronous input and synchronised output
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_q;
  logic [W-1:0] s2_d;

  always_comb begin
    s1_d = d;
    s2_d = s1_q;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign q = s2_q;

endmodule // pfc_sync

// >>> verif/pfc_flash_model.sv
`timescale 1ns/10ps
`include "pfc_defs.svh"

module pfc_flash_model #(
  parameter int AW = 18
) (
  // Bus pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_drive,
  // Test controls
  input wire logic slow,
  input wire logic skip_prog
);
  logic [7:0] mem [int];
  logic [AW-1:0] a_lat;
  logic [7:0] d_lat;
  logic [AW-1:0] p_addr;
  logic [7:0] p_data;
  logic tog = 1'b0;
  int seq = 0;
  // Busy kind: 0 idle, 1 program, 2 block erase, 3 chip erase
  int op = 0;
  wire wr = !ce_n && !we_n;
  wire rd = !ce_n && !oe_n;

  initial begin
    dq_out = 8'h00;
    dq_drive = 1'b0;
  end

  function automatic logic [7:0] rdmem(input int a);
    return mem.exists(a) ? mem[a] : `PFC_ERASED;
  endfunction

  task automatic start(input int k);
    op = k;
    p_addr = a_lat;
    p_data = d_lat;
  endtask

  task automatic decode();
    logic u1;
    logic u2;
    u1 = (a_lat[11:0] == `PFC_UNLK_A1);
    u2 = (a_lat[11:0] == `PFC_UNLK_A2);
    case (seq)
      0, 3: seq = (u1 && d_lat == `PFC_UNLK_D1) ? seq + 1 : 0;
      1, 4: seq = (u2 && d_lat == `PFC_UNLK_D2) ? seq + 1 : 0;
      2: seq = !u1 ? 0 : (d_lat == `PFC_CMD_PROG) ? 6 : (d_lat == `PFC_CMD_ESETUP) ? 3 : 0;
      5: begin
        if (d_lat == `PFC_CMD_BLK) start(2);
        else if (u1 && d_lat == `PFC_CMD_CHIP) start(3);
        seq = 0;
      end
      default: begin
        start(1);
        seq = 0;
      end
    endcase
  endtask

  always @(posedge wr) a_lat = addr;

  // data on earlier rise, busy ignores
  always @(negedge wr) begin
    d_lat = dq_in;
    if (op == 0) decode();
  end

  always @(op) begin
    if (op != 0) begin
      #(op == 1 ? (slow ? 18000 : 2000) : 10000);
      if (op == 1 && !skip_prog) mem[p_addr] = rdmem(p_addr) & p_data;
      if (op == 2) for (int i = 0; i < 128; i++) mem.delete(int'({p_addr[AW-1:7], 7'h00}) + i);
      if (op == 3) mem.delete();
      op = 0;
    end
  end

  always @(posedge rd) begin
    if (op == 0) dq_out = rdmem(addr);
    else begin
      tog = ~tog;
      dq_out = {op == 1 ? ~p_data[7] : 1'b0, tog, 6'h00};
    end
    dq_drive = 1'b1;
  end

  // released bus shows no stale value
  always @(negedge rd) begin
    dq_out = ~dq_out;
    dq_drive = 1'b0;
  end
endmodule // pfc_flash_model

// >>> verif/pfc_flash_host_tb.sv
`timescale 1ns/10ps
`include "pfc_defs.svh"

module pfc_flash_host_tb;
  import pfc_pkg::*;
  localparam int AW = 18;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  pfc_op_e cmd_op = PFC_OP_READ;
  logic [AW-1:0] cmd_addr = 18'h00000;
  logic [7:0] cmd_data = 8'h00;
  logic slow = 1'b0;
  logic skip_prog = 1'b0;
  logic cmd_ready, rsp_valid, rsp_ok, ce_n, oe_n, we_n, dq_oe, m_drive;
  logic [7:0] rsp_data, dq_o, m_dq;
  logic [AW-1:0] f_addr;
  wire [7:0] dq_bus = dq_oe ? dq_o : m_dq;
  int errors = 0;
  int check_count = 0;

  pfc_flash_host #(.AW(AW), .ERASE_TO_CYC(2000)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok), .rsp_data(rsp_data), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(f_addr), .flash_dq_i(dq_bus), .flash_dq_o(dq_o),
    .flash_dq_oe(dq_oe));

  pfc_flash_model #(.AW(AW)) u_flash (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr), .dq_in(dq_bus),
    .dq_out(m_dq), .dq_drive(m_drive), .slow(slow), .skip_prog(skip_prog));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One command through the port; returns cycles from take to answer
  task automatic run(input pfc_op_e op, input logic [AW-1:0] a, input logic [7:0] d,
                     input logic exp_ok, output int lat);
    int n;
    @(negedge clk_sys);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < 5000) begin
      @(negedge clk_sys);
      lat++;
    end
    if (n >= 100 || lat >= 5000) begin
      check("command timeout", 1, 0);
      end_of_test();
    end
    check("answer ok", rsp_ok, exp_ok);
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [7:0] exp);
    int lat;
    run(PFC_OP_READ, a, 8'h00, 1'b1, lat);
    // Answer one cycle after the last sampled access cycle
    check("read latency", lat, `PFC_ACC_CYC + 5);
    check("read data", rsp_data, exp);
  endtask

  task automatic t_reset_idle();
    @(negedge clk_sys);
    check("idle pins", {ce_n, oe_n, we_n, dq_oe, rsp_valid, cmd_ready}, 6'h39);
  endtask

  task automatic t_program();
    int lat;
    rd_chk(18'h00103, 8'hff);
    run(PFC_OP_PROG, 18'h00103, 8'h5a, 1'b1, lat);
    rd_chk(18'h00103, 8'h5a);
  endtask

  task automatic t_prog_not_erased();
    int lat;
    run(PFC_OP_PROG, 18'h00103, 8'h0f, 1'b0, lat);
    rd_chk(18'h00103, 8'h5a);
  endtask

  task automatic t_prog_slow();
    int lat;
    slow = 1'b1;
    run(PFC_OP_PROG, 18'h00200, 8'ha5, 1'b1, lat);
    slow = 1'b0;
    rd_chk(18'h00200, 8'ha5);
  endtask

  // Lost write: first never shows final bit 7, second fails the confirming reads
  task automatic t_prog_fault();
    int lat;
    skip_prog = 1'b1;
    run(PFC_OP_PROG, 18'h00300, 8'h12, 1'b0, lat);
    run(PFC_OP_PROG, 18'h00300, 8'hd2, 1'b0, lat);
    skip_prog = 1'b0;
    rd_chk(18'h00300, 8'hff);
  endtask

  task automatic t_blk_erase();
    int lat;
    run(PFC_OP_PROG, 18'h0017f, 8'h00, 1'b1, lat);
    run(PFC_OP_PROG, 18'h00180, 8'h3c, 1'b1, lat);
    run(PFC_OP_BLK_ERASE, 18'h00110, 8'h00, 1'b1, lat);
    rd_chk(18'h00103, 8'hff);
    rd_chk(18'h0017f, 8'hff);
    rd_chk(18'h00180, 8'h3c);
  endtask

  task automatic t_chip_erase();
    int lat;
    run(PFC_OP_CHIP_ERASE, 18'h00000, 8'h00, 1'b1, lat);
    rd_chk(18'h00180, 8'hff);
    rd_chk(18'h00200, 8'hff);
  endtask

  // Reset in the middle of a read, then a normal read
  task automatic t_reset_mid();
    @(negedge clk_sys);
    cmd_op = PFC_OP_READ;
    cmd_addr = 18'h00180;
    cmd_data = 8'h00;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
    srst = 1'b1;
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    check("pins after reset", {ce_n, oe_n, we_n, dq_oe, rsp_valid, cmd_ready}, 6'h39);
    check("addr after reset", f_addr, 0);
    check("data after reset", dq_o, 0);
    rd_chk(18'h00180, 8'hff);
  endtask

  always @(negedge clk_sys) begin
    if (!srst && !we_n && ce_n) check("strobe without select", 1, 0);
    if (!srst && !oe_n && !we_n) check("gate with strobe", 1, 0);
    if (!srst && dq_oe && m_drive) check("bus contention", 1, 0);
  end

  initial begin
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    t_reset_idle();
    t_program();
    t_prog_not_erased();
    t_prog_slow();
    t_prog_fault();
    t_blk_erase();
    t_chip_erase();
    t_reset_mid();
    end_of_test();
  end
endmodule // pfc_flash_host_tb
